// >>> rtl/sbs_map.vh
// Purpose: constants for the system bus slave interface
// Assumes: included by bare name from rtl files
// Notes:   response codes are {wait, last, error}
`ifndef SBS_MAP_VH
`define SBS_MAP_VH
`define SBS_RESP_DONE    3'h0
`define SBS_RESP_ERROR   3'h1
`define SBS_RESP_LAST    3'h2
`define SBS_RESP_RETRACT 3'h3
`define SBS_RESP_WAIT    3'h4
`define SBS_RESP_RETNEXT 3'h7
`define SBS_RESP_RSV_A   3'h5
`define SBS_RESP_RSV_B   3'h6
`define SBS_RESP_WAIT_BIT 2
`define SBS_ST_NOTSEL    2'h0
`define SBS_ST_SEL       2'h1
`define SBS_ST_RETRACT   2'h2
`define SBS_SIZE_WORD    2'h2
`define SBS_SIZE_HALF    2'h1
`define SBS_SIZE_BAD     2'h3
`define SBS_WAIT_DEF     4'h0
`define SBS_ZERO_WORD    32'h0000_0000
`endif

// >>> rtl/sbs_mem.v
// Purpose: word store behind the bus slave
// Assumes: one write and one read per clock
// Notes:   read data comes out of a register
`timescale 1ns/100ps
module sbs_mem #(
  parameter AW = 6,
  parameter DW = 32
) (
  // clock
  input  wire          i_ref_clk,
  // write port
  input  wire          i_wr_en,
  input  wire [AW-1:0] i_wr_addr,
  input  wire [DW-1:0] i_wr_data,
  input  wire [DW/8-1:0] i_wr_be,
  // read port
  input  wire          i_rd_en,
  input  wire [AW-1:0] i_rd_addr,
  output reg  [DW-1:0] o_rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer b;
  // byte-lane write and registered read
  always @(posedge i_ref_clk) begin
    for (b = 0; b < DW/8; b = b + 1) begin
      if (i_wr_en && i_wr_be[b]) begin
        mem[i_wr_addr][b*8 +: 8] <= i_wr_data[b*8 +: 8];
      end
    end
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule

// >>> rtl/sbs_slave.v
// Purpose: slave end of the shared system bus
// Assumes: bus clock is sampled as pins; i_ref_clk is far faster
// Notes:   bus clock edges found from synchronised level; tristates as oe
`timescale 1ns/100ps
`include "sbs_map.vh"
module sbs_slave #(
  parameter AW        = 6,
  parameter WAIT_CYC  = 4'h0,
  parameter ERR_EN    = 1'b1,
  parameter LAST_EN   = 1'b1,
  parameter RETR_EN   = 1'b1,
  parameter RETR_LIM  = 4'h8
) (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // bus pins in
  input  wire        i_bclk,
  input  wire        i_bus_rst_n,
  input  wire        i_dsel,
  input  wire [31:0] i_addr,
  input  wire        i_write,
  input  wire [1:0]  i_size,
  input  wire [31:0] i_data,
  // response pins out
  output reg         o_wait,
  output reg         o_last,
  output reg         o_error,
  output reg         o_resp_oe,
  // data pins out
  output reg  [31:0] o_data,
  output reg         o_data_oe,
  // user side
  input  wire        i_busy,
  output reg         o_wr_seen,
  output reg  [31:0] o_wr_word
);
  // synchronisers
  reg       clk_s1, rst_n_s1, sel_s1, wr_s1;
  reg       clk_s2, rst_n_s2, sel_s2, wr_s2;
  reg [1:0] siz_s1, siz_s2;
  reg [31:0] adr_s1, adr_s2, dat_s1, dat_s2;
  reg       clk_d;
  // transfer state
  reg [1:0]  state;
  reg [3:0]  wcnt;
  reg [3:0]  rcnt;
  reg [2:0]  resp;
  reg        xfer_wr;
  reg [1:0]  xfer_size;
  reg [AW-1:0] xfer_addr;
  reg        first_low;
  wire [31:0] rd_word;
  wire       fall;
  wire       rise;
  wire       bus_rst;
  wire       done_now;
  reg  [1:0] next_state;
  reg  [2:0] next_resp;
  wire       new_xfer;
  wire [1:0] cur_size;
  wire [AW-1:0] cur_addr;
  wire [3:0] cur_wcnt;

  // legal response only: reserved codes map to wait
  // a reserved code is never passed on to the response state
  function [2:0] sbs_legal;
    input [2:0] r;
    begin
      if (r == `SBS_RESP_RSV_A || r == `SBS_RESP_RSV_B) begin
        sbs_legal = `SBS_RESP_WAIT;
      end else begin
        sbs_legal = r;
      end
    end
  endfunction

  // byte enables from size and low address
  // halfword writes use lanes 0 and 1, byte writes lane 0 only; low address bits not wired in
  function [3:0] sbs_be;
    input [1:0] sz;
    input [1:0] a;
    begin
      if (sz == `SBS_SIZE_WORD) begin
        sbs_be = 4'hf;
      end else if (sz == `SBS_SIZE_HALF) begin
        sbs_be = a[1] ? 4'hc : 4'h3;
      end else begin
        sbs_be = 4'h1 << a;
      end
    end
  endfunction

  // two-flop synchronisers for every bus pin
  // every pin, bus clock included, is two flops away from any logic
  // clk_d is a third stage, read only by the edge detector
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_s1   <= 1'b0;
      rst_n_s1 <= 1'b0;
      sel_s1   <= 1'b0;
      wr_s1    <= 1'b0;
      clk_s2   <= 1'b0;
      rst_n_s2 <= 1'b0;
      sel_s2   <= 1'b0;
      wr_s2    <= 1'b0;
      siz_s1   <= 2'h0;
      siz_s2   <= 2'h0;
      adr_s1   <= `SBS_ZERO_WORD;
      adr_s2   <= `SBS_ZERO_WORD;
      dat_s1   <= `SBS_ZERO_WORD;
      dat_s2   <= `SBS_ZERO_WORD;
      clk_d    <= 1'b0;
    end else begin
      clk_s1    <= i_bclk;
      rst_n_s1  <= i_bus_rst_n;
      sel_s1    <= i_dsel;
      wr_s1     <= i_write;
      siz_s1    <= i_size;
      adr_s1    <= i_addr;
      dat_s1    <= i_data;
      clk_s2    <= clk_s1;
      rst_n_s2  <= rst_n_s1;
      sel_s2    <= sel_s1;
      wr_s2     <= wr_s1;
      siz_s2    <= siz_s1;
      adr_s2    <= adr_s1;
      dat_s2    <= dat_s1;
      clk_d     <= clk_s2;
    end
  end

  // edge strobes last one ref cycle and trail the pin by two
  // bus clock idles low after reset, so no false edge at start
  assign fall    = clk_d & ~clk_s2;
  assign rise    = ~clk_d & clk_s2;
  assign bus_rst = ~rst_n_s2;
  assign done_now = ~resp[`SBS_RESP_WAIT_BIT];

  // controls this fall answers for: fresh ones when a transfer starts
  // hazard: the held copies still belong to the previous transfer here
  assign new_xfer = sel_s2 && (state == `SBS_ST_NOTSEL || done_now);
  assign cur_size = new_xfer ? siz_s2 : xfer_size;
  assign cur_addr = new_xfer ? adr_s2[AW+1:2] : xfer_addr;
  assign cur_wcnt = new_xfer ? WAIT_CYC : wcnt;

  // next response chosen at each falling edge while selected
  // priority: retnext, wait, error, last, done
  // busy is a same-clock user level, read without flops
  always @* begin
    next_resp = `SBS_RESP_DONE;
    if (i_busy && RETR_EN && rcnt >= RETR_LIM) begin
      next_resp = `SBS_RESP_RETNEXT;
    end else if (i_busy || cur_wcnt != 4'h0) begin
      next_resp = `SBS_RESP_WAIT;
    end else if (ERR_EN && (cur_size == `SBS_SIZE_BAD)) begin
      next_resp = `SBS_RESP_ERROR;
    end else if (LAST_EN && (&cur_addr)) begin
      next_resp = `SBS_RESP_LAST;
    end else begin
      next_resp = `SBS_RESP_DONE;
    end
  end

  // falling-edge state machine
  // retract holds one bus cycle, then back to selected or idle
  always @* begin
    next_state = state;
    case (state)
      `SBS_ST_NOTSEL: begin
        if (sel_s2) begin
          next_state = `SBS_ST_SEL;
        end
      end
      `SBS_ST_SEL: begin
        // retract state entered on the fall that answers retnext
        if (done_now && !sel_s2) begin
          next_state = `SBS_ST_NOTSEL;
        end else if (next_resp == `SBS_RESP_RETNEXT) begin
          next_state = `SBS_ST_RETRACT;
        end
      end
      `SBS_ST_RETRACT: begin
        next_state = sel_s2 ? `SBS_ST_SEL : `SBS_ST_NOTSEL;
      end
      default: begin
        next_state = `SBS_ST_NOTSEL;
      end
    endcase
  end

  // state, controls and response, all moved on bus clock fall
  // bus reset holds state, response and counters idle until the pin goes high again; held controls keep their values
  // rcnt counts busy answers; it clears on a retract or once ready
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state     <= `SBS_ST_NOTSEL;
      resp      <= `SBS_RESP_DONE;
      wcnt      <= 4'h0;
      rcnt      <= 4'h0;
      xfer_wr   <= 1'b0;
      xfer_size <= 2'h0;
      xfer_addr <= {AW{1'b0}};
      first_low <= 1'b0;
    end else if (bus_rst) begin
      state     <= `SBS_ST_NOTSEL;
      resp      <= `SBS_RESP_DONE;
      wcnt      <= 4'h0;
      rcnt      <= 4'h0;
      first_low <= 1'b0;
    end else if (fall) begin
      state <= next_state;
      if (new_xfer) begin
        // new transfer: take controls
        xfer_wr   <= wr_s2;
        xfer_size <= siz_s2;
        xfer_addr <= adr_s2[AW+1:2];
        wcnt      <= WAIT_CYC;
        first_low <= 1'b1;
      end else begin
        first_low <= 1'b0;
        if (wcnt != 4'h0) begin
          wcnt <= wcnt - 4'h1;
        end
      end
      if (state == `SBS_ST_RETRACT) begin
        resp <= `SBS_RESP_RETRACT;
        rcnt <= 4'h0;
      end else if (sel_s2) begin
        resp <= sbs_legal(next_resp);
        if (i_busy && rcnt < RETR_LIM) begin
          rcnt <= rcnt + 4'h1;
        end else if (!i_busy) begin
          rcnt <= 4'h0;
        end
      end else begin
        resp <= `SBS_RESP_DONE;
      end
    end else if (rise) begin
      first_low <= 1'b0;
    end
  end

  // response pins: driven only in low phase while selected
  // oe set at the fall, dropped at the rise: the high phase is left
  // free for the next driver of the response lines
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_resp_oe <= 1'b0;
      o_wait    <= 1'b0;
      o_last    <= 1'b0;
      o_error   <= 1'b0;
    end else begin
      if (bus_rst || !sel_s2) begin
        o_resp_oe <= 1'b0;
      end else if (fall) begin
        o_resp_oe <= 1'b1;
      end else if (rise) begin
        o_resp_oe <= 1'b0;
      end
      if (fall) begin
        o_wait  <= (state == `SBS_ST_RETRACT) ? 1'b0 : next_resp[2];
        o_last  <= (state == `SBS_ST_RETRACT) ? 1'b1 : next_resp[1];
        o_error <= (state == `SBS_ST_RETRACT) ? 1'b1 : next_resp[0];
      end
    end
  end

  // write capture at falling edge while selected
  // data taken at the closing fall, when the master holds it valid
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_seen <= 1'b0;
      o_wr_word <= `SBS_ZERO_WORD;
    end else begin
      o_wr_seen <= 1'b0;
      if (fall && state == `SBS_ST_SEL && xfer_wr && done_now && !bus_rst) begin
        o_wr_seen <= 1'b1;
        o_wr_word <= dat_s2;
      end
    end
  end

  // read data drive: final high phase only, never first phase
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data_oe <= 1'b0;
      o_data    <= `SBS_ZERO_WORD;
    end else begin
      // drive from the high phase of a completed read to the next fall
      // a rise never falls inside the first low phase of a transfer
      if (bus_rst || state == `SBS_ST_NOTSEL || xfer_wr) begin
        o_data_oe <= 1'b0;
      end else if (rise && (resp == `SBS_RESP_DONE || resp == `SBS_RESP_LAST)) begin
        o_data_oe <= 1'b1;
        o_data    <= rd_word;
      end else if (fall || first_low) begin
        o_data_oe <= 1'b0;
      end
    end
  end

  // word store
  // read port always on: the word is ready well before any rise
  sbs_mem #(
    .AW (AW),
    .DW (32)
  ) sbs_mem_inst (
    .i_ref_clk (i_ref_clk),
    .i_wr_en   (o_wr_seen),
    .i_wr_addr (xfer_addr),
    .i_wr_data (o_wr_word),
    .i_wr_be   (sbs_be(xfer_size, 2'h0)),
    .i_rd_en   (1'b1),
    .i_rd_addr (xfer_addr),
    .o_rd_data (rd_word)
  );
endmodule

// >>> sim/sbs_slave_assertions.sv
// Purpose: port checks for the bus slave
// Assumes: bus clock phase of 10 ref cycles
// Notes:   bound to sbs_slave after endmodule
`timescale 1ns/100ps
module sbs_slave_chk (
  // watched ports
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_bclk,
  input wire i_bus_rst_n,
  input wire i_dsel,
  input wire i_write,
  input wire o_wait,
  input wire o_last,
  input wire o_error,
  input wire o_resp_oe,
  input wire o_data_oe,
  input wire o_wr_seen
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_resp_off_high: assert property ($rose(i_bclk) |-> ##[1:5] !o_resp_oe)
    else $error("response still driven in high phase");
  a_resp_in_low: assert property (o_resp_oe |-> !$past(i_bclk, 3) || !$past(i_bclk, 5))
    else $error("response driven outside low phase");
  a_no_reserved: assert property (o_resp_oe |-> !(o_wait && (o_last ^ o_error)))
    else $error("reserved response driven");
  a_off_unsel: assert property (o_resp_oe |-> i_dsel)
    else $error("response driven while not selected");
  a_rst_hiz: assert property (!i_bus_rst_n [*5] |-> !o_resp_oe && !o_data_oe)
    else $error("pins driven in bus reset");
  a_data_high: assert property (o_data_oe |-> $past(i_bclk, 3) || $past(i_bclk, 5))
    else $error("data driven in low phase");
  a_answer_sel: assert property ($fell(i_bclk) && i_dsel && i_bus_rst_n
    && $past(i_bus_rst_n, 4) |-> ##[2:6] o_resp_oe)
    else $error("no response when selected");
  a_read_data: assert property ($rose(i_bclk) && o_resp_oe && !o_wait && !o_last
    && !o_error && !i_write |-> ##[2:6] o_data_oe)
    else $error("read data not driven");
  a_wr_pulse: assert property (o_wr_seen |=> !o_wr_seen)
    else $error("write pulse too long");
endmodule
bind sbs_slave sbs_slave_chk sbs_slave_chk_inst (.i_ref_clk, .i_rst, .i_bclk, .i_bus_rst_n,
  .i_dsel, .i_write, .o_wait, .o_last, .o_error, .o_resp_oe, .o_data_oe, .o_wr_seen);

// >>> sim/sbs_bus_master.sv
// Purpose: bus master and decoder model
// Assumes: nonsequential transfers only
// Notes:   released data lines toggle each cycle
`timescale 1ns/100ps
module sbs_bus_master #(
  parameter HALF = 10
) (
  // clock
  input  wire        i_ref_clk,
  // slave pins
  input  wire        i_wait,
  input  wire        i_last,
  input  wire        i_error,
  input  wire        i_resp_oe,
  input  wire [31:0] i_sdata,
  input  wire        i_sdata_oe,
  // bus pins
  output reg         o_bclk,
  output reg         o_dsel,
  output reg  [31:0] o_addr,
  output reg         o_write,
  output reg  [1:0]  o_size,
  output wire [31:0] o_bd
);
  reg [3:0]  cnt;
  reg        m_oe;
  reg [31:0] m_data;
  reg [31:0] rel;
  initial begin
    {o_bclk, o_dsel, o_addr, o_write, o_size, m_oe, m_data, cnt} = 0;
    rel = 32'h5a5a_a5a5;
  end
  // free running bus clock
  always @(posedge i_ref_clk) begin
    rel <= ~rel;
    cnt <= (cnt == HALF - 1) ? 4'h0 : cnt + 4'h1;
    if (cnt == HALF - 1) o_bclk <= ~o_bclk;
  end
  // wired data bus
  assign o_bd = i_sdata_oe ? i_sdata : (m_oe ? m_data : rel);
  // one transfer, select set in high phase
  task xfer(input w, input [31:0] a, input [31:0] wd, input [1:0] sz,
            output [2:0] resp, output [2:0] prev, output [3:0] nw, output [31:0] rd);
    begin
      @(posedge o_bclk);
      repeat (HALF / 2) @(posedge i_ref_clk);
      #1;
      o_dsel = 1'b1;
      o_addr = a;
      o_write = w;
      o_size = sz;
      nw = 4'h0;
      resp = 3'h4;
      prev = 3'h0;
      while (resp[2] && nw < 4'hf) begin
        @(posedge o_bclk);
        prev = resp;
        resp = i_resp_oe ? {i_wait, i_last, i_error} : 3'h5;
        if (resp[2]) nw = nw + 4'h1;
        repeat (HALF / 2) @(posedge i_ref_clk);
        #1;
        m_oe = w; // no early drive used
        m_data = wd;
      end
      o_dsel = 1'b0;
      @(negedge o_bclk);
      rd = o_bd;
      repeat (HALF / 2) @(posedge i_ref_clk);
      #1;
      m_oe = 1'b0;
    end
  endtask
endmodule

// >>> sim/system_bus_slave_interface_tb.sv
// Purpose: self-checking bench for sbs_slave
// Assumes: retract after 4 busy waits
// Notes:   master model drives the bus
`timescale 1ns/100ps
module system_bus_slave_interface_tb;
  reg         i_ref_clk, i_rst, i_bus_rst_n, i_busy;
  wire        i_bclk, i_dsel, i_write, o_wait, o_last, o_error, o_resp_oe, o_data_oe, o_wr_seen;
  wire [31:0] i_addr, i_data, o_data, o_wr_word;
  wire [1:0]  i_size;
  integer     errors, num_checks, wr_cnt;
  reg  [31:0] wr_last, rd;
  reg  [2:0]  resp, prev;
  reg  [3:0]  nw;
  sbs_slave #(.RETR_LIM(4'h4)) sbs_slave_inst (.i_ref_clk, .i_rst, .i_bclk, .i_bus_rst_n,
    .i_dsel, .i_addr, .i_write, .i_size, .i_data, .o_wait, .o_last, .o_error, .o_resp_oe,
    .o_data, .o_data_oe, .i_busy, .o_wr_seen, .o_wr_word);
  sbs_bus_master sbs_bus_master_inst (.i_ref_clk(i_ref_clk), .i_wait(o_wait), .i_last(o_last),
    .i_error(o_error), .i_resp_oe(o_resp_oe), .i_sdata(o_data), .i_sdata_oe(o_data_oe),
    .o_bclk(i_bclk), .o_dsel(i_dsel), .o_addr(i_addr), .o_write(i_write), .o_size(i_size),
    .o_bd(i_data));
  initial begin
    i_ref_clk = 0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  // count write completions
  always @(posedge i_ref_clk) if (o_wr_seen === 1'b1) begin
    wr_cnt <= wr_cnt + 1;
    wr_last <= o_wr_word;
  end
  task chk(input [95:0] nm, input [31:0] exp, input [31:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task xf(input w, input [31:0] a, input [31:0] wd, input [1:0] sz);
    sbs_bus_master_inst.xfer(w, a, wd, sz, resp, prev, nw, rd);
  endtask
  task t_wr_rd;
    integer c;
    begin
      c = wr_cnt;
      xf(1'b1, 32'h10, 32'h1234_abcd, 2'h2);
      repeat (4) @(posedge i_ref_clk);
      chk("wr resp", 0, resp);
      chk("wr cnt", c + 1, wr_cnt);
      chk("wr word", 32'h1234_abcd, wr_last);
      xf(1'b0, 32'h10, 0, 2'h2);
      chk("rd resp", 0, resp);
      chk("rd data", 32'h1234_abcd, rd);
    end
  endtask
  task t_codes;
    begin
      xf(1'b0, 32'hfc, 0, 2'h2);
      chk("last", 3'h2, resp);
      xf(1'b0, 32'h20, 0, 2'h3);
      chk("error", 3'h1, resp);
    end
  endtask
  task t_wait;
    begin
      i_busy = 1'b1;
      fork
        xf(1'b0, 32'h10, 0, 2'h2);
        begin repeat (2) @(posedge i_bclk); #1 i_busy = 1'b0; end
      join
      chk("wt resp", 0, resp);
      chk("wt seen", 1, nw != 0);
      chk("wt data", 32'h1234_abcd, rd);
    end
  endtask
  task t_retract;
    begin
      i_busy = 1'b1;
      xf(1'b0, 32'h10, 0, 2'h2);
      chk("retnext", 3'h7, prev);
      chk("retract", 3'h3, resp);
      i_busy = 1'b0;
      xf(1'b0, 32'h10, 0, 2'h2);
      chk("retry", 0, resp);
      chk("retry dat", 32'h1234_abcd, rd);
    end
  endtask
  task t_bus_rst;
    begin
      fork
        xf(1'b0, 32'h10, 0, 2'h2);
        begin
          @(negedge i_bclk);
          #1 i_bus_rst_n = 1'b0;
          repeat (8) @(posedge i_ref_clk);
          #1 chk("rst roe", 0, o_resp_oe);
          chk("rst doe", 0, o_data_oe);
          repeat (40) @(posedge i_ref_clk);
          #1 i_bus_rst_n = 1'b1;
        end
      join
      xf(1'b0, 32'h10, 0, 2'h2);
      chk("after rst", 0, resp);
    end
  endtask
  initial begin
    {errors, num_checks, wr_cnt, wr_last} = 0;
    i_rst = 1'b1;
    i_bus_rst_n = 1'b0;
    i_busy = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    i_bus_rst_n = 1'b1;
    t_wr_rd;
    t_codes;
    t_wait;
    t_retract;
    t_bus_rst;
    conclude;
  end
  initial begin
    #200000;
    errors = errors + 1;
    conclude;
  end
endmodule
